/* File: core/burst_read_config.sv */
// Purpose: Bus access configuration and synchronous burst read sequencing
// Assumes: Command path decodes the set-configuration sequence and pulses CFG_LOAD
// Notes:   CLOCK_PIN is sampled on CORE_CLK; the selected edge is detected from it
// Functional notes
// RULE_01 - Reset gives asynchronous reads, read select one
// RULE_02 - Read select picks asynchronous or synchronous reads
// RULE_03 - Bursts run freely across blocks and banks
// RULE_04 - Latency codes two to five set cycles
// RULE_05 - Host sizes latency and clock period
// RULE_06 - Power-down bit chooses standby or power-down
// RULE_07 - Reset clears the power-down enable
// RULE_08 - Wait timing bit shifts stall one cycle
// RULE_09 - Stall only in continuous or no-wrap bursts
// RULE_10 - Burst order bit selects interleaved or sequential
// RULE_11 - Edge select bit picks falling or rising
// RULE_12 - Wrap disable bit stops wrapping at group
// RULE_13 - Length field gives four, eight or continuous
// RULE_14 - Host keeps sequential order for continuous bursts
// RULE_15 - Aligned start never inserts wait states
// RULE_16 - Offset start waits at first 64-boundary
// RULE_17 - Wait inserted at most once per burst
// RULE_18 - Spare bits have no effect
// RULE_19 - Configuration loads only via command path
// RULE_20 - Interleaved address XORs count into low bits
// RULE_21 - Counting happens on the selected clock edge
`timescale 1ns/1ns
`include "burst_read_defs.svh"
module burst_read_config #(
    parameter int ADDR_WIDTH = 22
) (
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESETN,
    input  wire logic                  CFG_LOAD,
    input  wire logic [15:0]           CFG_DATA,
    input  wire logic                  RESET_POWERDOWN_PIN_N,
    input  wire logic                  CHIP_ENABLE_N,
    input  wire logic                  LATCH_ENABLE_N,
    input  wire logic                  CLOCK_PIN,
    input  wire logic [ADDR_WIDTH-1:0] ADDRESS,
    output logic                       ASYNC_READ,
    output logic                       STALL_INDICATOR,
    output logic                       DATA_VALID,
    output logic [ADDR_WIDTH-1:0]      WORD_ADDRESS,
    output burst_read_pkg::power_mode_type POWER_MODE,
    output logic                       LATENCY_RESERVED
);
    import burst_read_pkg::*;

    logic [15:0]     config_reg;
    burst_state_type state_reg;
    burst_state_type state_next;
    logic            clk_prev_reg;
    logic [2:0]      lat_count_reg;
    logic [1:0]      stall_count_reg;
    logic            stall_done_reg;
    logic [3:0]      words_left_reg;
    logic [1:0]      start_offset_reg;
    logic            stall_output_reg;
    logic            valid_reg;
    logic [ADDR_WIDTH-1:0] word_addr_reg;
    power_mode_type  power_reg;

    logic       read_select_bit;
    logic [2:0] latency_field;
    logic       powerdown_enable_bit;
    logic       wait_timing_bit;
    logic       burst_order_bit;
    logic       clock_edge_select_bit;
    logic       wrap_disable_bit;
    logic [2:0] burst_length_field;
    logic       active_edge;
    logic       continuous;
    logic       stall_allowed;
    logic       cross_next;
    logic       enter_stall;
    logic       latch_now;

    burst_addr_if #(.ADDR_WIDTH(ADDR_WIDTH)) addr_bus ();

    burst_addr_unit #(.ADDR_WIDTH(ADDR_WIDTH)) u_addr (
        .CORE_CLK (CORE_CLK),
        .RESETN   (RESETN),
        .addr_bus (addr_bus)
    );

    // Field extraction; bits 14, 9, 5 and 4 are stored but never read
    assign read_select_bit       = config_reg[`READ_SELECT_POS]; // RULE_18
    assign latency_field         = config_reg[`LATENCY_HI_POS:`LATENCY_LO_POS];
    assign powerdown_enable_bit  = config_reg[`POWERDOWN_EN_POS];
    assign wait_timing_bit       = config_reg[`WAIT_TIMING_POS];
    assign burst_order_bit       = config_reg[`BURST_ORDER_POS];
    assign clock_edge_select_bit = config_reg[`CLOCK_EDGE_POS];
    assign wrap_disable_bit      = config_reg[`WRAP_DISABLE_POS];
    assign burst_length_field    = config_reg[`BURST_LEN_HI_POS:`BURST_LEN_LO_POS];

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            config_reg <= `CFG_RESET_VALUE; // RULE_01 RULE_07
        else if (!RESET_POWERDOWN_PIN_N)
            config_reg <= `CFG_RESET_VALUE; // RULE_07
        else if (CFG_LOAD)
            config_reg <= CFG_DATA; // RULE_19
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            power_reg <= MODE_STANDBY;
        else if (!RESET_POWERDOWN_PIN_N)
            // The low level clears the enable bit, so power-down must hold itself
            power_reg <= (powerdown_enable_bit || power_reg == MODE_POWERDOWN)
                         ? MODE_POWERDOWN : MODE_STANDBY; // RULE_06
        else
            power_reg <= MODE_ACTIVE;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            clk_prev_reg <= 1'b0;
        else
            clk_prev_reg <= CLOCK_PIN;
    end

    assign active_edge = clock_edge_select_bit ? (CLOCK_PIN && !clk_prev_reg)
                                               : (!CLOCK_PIN && clk_prev_reg); // RULE_11 RULE_21
    assign continuous    = (burst_length_field == `BURST_LEN_CONT); // RULE_13
    assign stall_allowed = continuous || wrap_disable_bit; // RULE_09
    assign latch_now     = active_edge && !LATCH_ENABLE_N && !CHIP_ENABLE_N
                           && !read_select_bit && RESET_POWERDOWN_PIN_N; // RULE_02
    assign cross_next    = (addr_bus.word_addr[5:0] == `BOUNDARY_MASK);
    assign enter_stall   = stall_allowed && !stall_done_reg && cross_next
                           && (start_offset_reg != 2'h0); // RULE_15 RULE_16 RULE_17

    assign addr_bus.load        = latch_now && state_reg == IDLE_ST;
    assign addr_bus.start_addr  = ADDRESS;
    assign addr_bus.interleaved = !burst_order_bit; // RULE_10
    assign addr_bus.wrap        = !wrap_disable_bit;
    assign addr_bus.group_sel   = continuous ? 2'h2 :
                                  (burst_length_field == `BURST_LEN_EIGHT) ? 2'h1 : 2'h0;
    // Leaving the wait state steps at once, so the wait lasts exactly offset edges
    assign addr_bus.step        = active_edge && words_left_reg != 4'h1
                                  && ((state_reg == DATA_ST && !enter_stall)
                                      || (state_reg == STALL_ST
                                          && stall_count_reg == 2'h1)); // RULE_16

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            IDLE_ST:
                if (latch_now)
                    state_next = LATENCY_ST;
            LATENCY_ST:
                if (active_edge && lat_count_reg <= 3'h1)
                    state_next = DATA_ST; // RULE_04
            DATA_ST:
                if (active_edge)
                begin
                    if (!continuous && words_left_reg == 4'h1)
                        state_next = IDLE_ST;
                    else if (enter_stall)
                        state_next = STALL_ST;
                end
            STALL_ST:
                if (active_edge && stall_count_reg == 2'h1)
                    state_next = DATA_ST;
            default:
                state_next = IDLE_ST;
        endcase
        if (CHIP_ENABLE_N || !RESET_POWERDOWN_PIN_N || read_select_bit)
            state_next = IDLE_ST;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            state_reg <= IDLE_ST;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            lat_count_reg    <= 3'h0;
            words_left_reg   <= 4'h0;
            start_offset_reg <= 2'h0;
        end
        else if (addr_bus.load)
        begin
            lat_count_reg    <= latency_field; // RULE_04
            start_offset_reg <= ADDRESS[1:0];
            words_left_reg   <= (burst_length_field == `BURST_LEN_EIGHT) ? `WORDS_EIGHT
                                                                           : `WORDS_FOUR;
        end
        else if (active_edge)
        begin
            if (state_reg == LATENCY_ST)
                lat_count_reg <= lat_count_reg - 3'h1;
            if (state_reg == DATA_ST && !enter_stall && !continuous)
                words_left_reg <= words_left_reg - 4'h1; // RULE_13
            if (state_reg == STALL_ST && stall_count_reg == 2'h1 && !continuous)
                words_left_reg <= words_left_reg - 4'h1; // RULE_13
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            stall_count_reg <= 2'h0;
            stall_done_reg  <= 1'b0;
        end
        else if (addr_bus.load)
        begin
            stall_count_reg <= 2'h0;
            stall_done_reg  <= 1'b0;
        end
        else if (active_edge && state_reg == DATA_ST && enter_stall)
        begin
            stall_count_reg <= start_offset_reg; // RULE_16
            stall_done_reg  <= 1'b1; // RULE_17
        end
        else if (active_edge && state_reg == STALL_ST)
            stall_count_reg <= stall_count_reg - 2'h1;
    end

    // Early mode raises the indicator one cycle ahead and drops it one cycle early
    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
            stall_output_reg <= 1'b0;
        else if (active_edge)
        begin
            if (wait_timing_bit)
                stall_output_reg <= (stall_allowed && !stall_done_reg
                                     && start_offset_reg != 2'h0
                                     && ((state_reg == DATA_ST && addr_bus.step
                                          && addr_bus.word_addr[5:0] == 6'h3E)
                                         || (state_reg == LATENCY_ST
                                             && state_next == DATA_ST && cross_next)))
                                    || (state_reg == STALL_ST && stall_count_reg > 2'h2)
                                    || (state_reg == DATA_ST && enter_stall
                                        && start_offset_reg > 2'h1); // RULE_08
            else
                stall_output_reg <= (state_reg == DATA_ST && enter_stall)
                                    || (state_reg == STALL_ST && stall_count_reg > 2'h1); // RULE_08
        end
        else if (state_next == IDLE_ST)
            stall_output_reg <= 1'b0; // RULE_09
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            valid_reg     <= 1'b0;
            word_addr_reg <= '0;
        end
        else
        begin
            valid_reg     <= (state_next == DATA_ST);
            word_addr_reg <= addr_bus.word_addr;
        end
    end

    assign ASYNC_READ       = read_select_bit;
    assign STALL_INDICATOR  = stall_output_reg && state_reg != IDLE_ST
                              && state_reg != LATENCY_ST; // RULE_09
    assign DATA_VALID       = valid_reg;
    assign WORD_ADDRESS     = word_addr_reg;
    assign POWER_MODE       = power_reg;
    assign LATENCY_RESERVED = (latency_field < `LATENCY_MIN_CODE)
                              || (latency_field > `LATENCY_MAX_CODE); // RULE_04

    reset_async_a: assert property (@(posedge CORE_CLK)
        $rose(RESETN) |-> config_reg[`READ_SELECT_POS] && !config_reg[`POWERDOWN_EN_POS])
        else $error("Reset left config not asynchronous"); // RULE_01

    no_stall_async_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        read_select_bit |-> !STALL_INDICATOR)
        else $error("Stall shown in asynchronous read"); // RULE_09

    no_stall_latency_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        state_reg == LATENCY_ST |-> !STALL_INDICATOR)
        else $error("Stall shown during latency"); // RULE_09

    powerdown_mode_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (!RESET_POWERDOWN_PIN_N && powerdown_enable_bit) |=> POWER_MODE == MODE_POWERDOWN)
        else $error("Power-down not entered"); // RULE_06

    sequence stall_entry_s;
        state_reg == DATA_ST && active_edge && enter_stall;
    endsequence

    stall_once_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        stall_entry_s |=> stall_done_reg)
        else $error("Stall entry not recorded"); // RULE_17

    aligned_no_stall_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (state_reg != IDLE_ST && start_offset_reg == 2'h0) |-> state_reg != STALL_ST)
        else $error("Wait state on aligned start"); // RULE_15

    no_wrap_stall_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (!stall_allowed && state_reg == DATA_ST) |-> !enter_stall)
        else $error("Wait in wrapped fixed burst"); // RULE_09

    config_load_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        (!CFG_LOAD && RESET_POWERDOWN_PIN_N) |=> $stable(config_reg))
        else $error("Config changed without load"); // RULE_19
endmodule : burst_read_config

/* File: core/burst_read_defs.svh */
// Purpose: Offsets, field positions, reset values and counts for the burst read block
// Assumes: 16-bit bus access configuration word loaded by the command path
// Notes:   Included by its bare name
`ifndef BURST_READ_DEFS_SVH
`define BURST_READ_DEFS_SVH

`define CFG_WIDTH           16
`define CFG_RESET_VALUE     16'h99CF
`define READ_SELECT_POS     15
`define LATENCY_HI_POS      13
`define LATENCY_LO_POS      11
`define POWERDOWN_EN_POS    10
`define WAIT_TIMING_POS     8
`define BURST_ORDER_POS     7
`define CLOCK_EDGE_POS      6
`define WRAP_DISABLE_POS    3
`define BURST_LEN_HI_POS    2
`define BURST_LEN_LO_POS    0
`define LATENCY_MIN_CODE    3'h2
`define LATENCY_MAX_CODE    3'h5
`define BURST_LEN_FOUR      3'h1
`define BURST_LEN_EIGHT     3'h2
`define BURST_LEN_CONT      3'h7
`define WORDS_FOUR          4'h4
`define WORDS_EIGHT         4'h8
`define BOUNDARY_MASK       6'h3F

`endif

/* File: core/burst_read_pkg.sv */
// Purpose: Types shared by the burst read block
// Assumes: Constants come from burst_read_defs.svh
// Notes:   States are one-hot
package burst_read_pkg;

    typedef enum logic [3:0] {
        IDLE_ST    = 4'h1,
        LATENCY_ST = 4'h2,
        DATA_ST    = 4'h4,
        STALL_ST   = 4'h8
    } burst_state_type;

    typedef enum logic [1:0] {
        MODE_STANDBY   = 2'h0,
        MODE_ACTIVE    = 2'h1,
        MODE_POWERDOWN = 2'h2
    } power_mode_type;

endpackage : burst_read_pkg

/* File: core/burst_addr_if.sv */
// Purpose: Carries burst address stepping between the sequencer and the address unit
// Assumes: One clock domain
// Notes:   Sequencer drives controls, address unit returns the word address
`timescale 1ns/1ns
interface burst_addr_if #(parameter int ADDR_WIDTH = 22);
    logic                  load;
    logic                  step;
    logic [ADDR_WIDTH-1:0] start_addr;
    logic                  interleaved;
    logic                  wrap;
    logic [1:0]            group_sel;
    logic [ADDR_WIDTH-1:0] word_addr;
    logic [2:0]            word_count;

    modport sequencer (output load, step, start_addr, interleaved, wrap, group_sel,
                       input word_addr, word_count);
    modport unit      (input load, step, start_addr, interleaved, wrap, group_sel,
                       output word_addr, word_count);
endinterface : burst_addr_if

/* File: core/burst_addr_unit.sv */
// Purpose: Produces the burst word address for sequential, interleaved, wrap and no-wrap
// Assumes: group_sel 0 is four words, 1 is eight words, 2 is continuous
// Notes:   Continuous bursts always count linearly
`timescale 1ns/1ns
module burst_addr_unit #(
    parameter int ADDR_WIDTH = 22
) (
    input  wire logic    CORE_CLK,
    input  wire logic    RESETN,
    burst_addr_if.unit   addr_bus
);
    logic [ADDR_WIDTH-1:0] base_reg;
    logic [ADDR_WIDTH-1:0] linear_reg;
    logic [2:0]            count_reg;
    logic [2:0]            group_mask;
    logic [2:0]            low_next;
    logic [2:0]            count_next;

    assign group_mask = (addr_bus.group_sel == 2'h0) ? 3'h3 : 3'h7;
    assign count_next = (count_reg + 3'h1) & group_mask;

    always_comb
    begin
        if (addr_bus.interleaved && addr_bus.group_sel != 2'h2)
            low_next = base_reg[2:0] ^ count_next; // RULE_20 RULE_10
        else
            low_next = (base_reg[2:0] + count_next) & group_mask; // RULE_10
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (!RESETN)
        begin
            base_reg   <= '0;
            linear_reg <= '0;
            count_reg  <= 3'h0;
        end
        else if (addr_bus.load)
        begin
            base_reg   <= addr_bus.start_addr;
            linear_reg <= addr_bus.start_addr;
            count_reg  <= 3'h0;
        end
        else if (addr_bus.step)
        begin
            count_reg <= count_next;
            if (addr_bus.group_sel == 2'h2 || !addr_bus.wrap)
                linear_reg <= linear_reg + 1'b1; // RULE_12 RULE_03
            else
                linear_reg <= (base_reg & ~{{(ADDR_WIDTH-3){1'b0}}, group_mask})
                              | {{(ADDR_WIDTH-3){1'b0}}, low_next & group_mask}; // RULE_12
        end
    end

    assign addr_bus.word_addr  = linear_reg;
    assign addr_bus.word_count = count_reg;
endmodule : burst_addr_unit

/* File: verification/burst_host_model.sv */
// Purpose: Host memory controller that drives burst reads at the pins
// Assumes: Pin clock runs only inside a burst and is slower than half the core clock
// Notes:   Released address lines show the inverse of their last value
`timescale 1ns/1ns
module burst_host_model #(
    parameter int ADDR_WIDTH = 22
) (
    input  wire logic             CORE_CLK,
    output logic                  CLOCK_PIN,
    output logic                  LATCH_ENABLE_N,
    output logic                  CHIP_ENABLE_N,
    output logic [ADDR_WIDTH-1:0] ADDRESS
);
    // Long pin period keeps every latency code within the access time
    int half_cycles = 3;

    initial
    begin
        CLOCK_PIN      = 1'b0;
        LATCH_ENABLE_N = 1'b1;
        CHIP_ENABLE_N  = 1'b1;
        ADDRESS        = '0;
    end

    task automatic pin_cycle();
        repeat (half_cycles) @(posedge CORE_CLK);
        #2 CLOCK_PIN = 1'b1;
        repeat (half_cycles) @(posedge CORE_CLK);
        #2 CLOCK_PIN = 1'b0;
    endtask : pin_cycle

    task automatic burst(input logic [ADDR_WIDTH-1:0] start, input int cycles);
        @(posedge CORE_CLK);
        #2;
        CHIP_ENABLE_N  = 1'b0;
        LATCH_ENABLE_N = 1'b0;
        ADDRESS        = start;
        pin_cycle();
        // Latch held past the edge so a sampled edge still sees it low
        repeat (half_cycles - 1) @(posedge CORE_CLK);
        #2;
        LATCH_ENABLE_N = 1'b1;
        ADDRESS        = ~start;
        repeat (cycles) pin_cycle();
        @(posedge CORE_CLK);
        #2;
        CHIP_ENABLE_N = 1'b1;
        ADDRESS       = start;
    endtask : burst
endmodule : burst_host_model

/* File: verification/tb_burst_read_config.sv */
// Purpose: Self-checking bench for the burst read configuration block
// Assumes: Host model drives burst pins; bench drives config, reset and power pins
// Notes:   Stall lengths are judged in whole pin clock periods
`timescale 1ns/1ns
module tb_burst_read_config;
    import burst_read_pkg::*;
    localparam int AW      = 22;
    localparam int CEILING = 40000;

    logic           CORE_CLK              = 1'b0;
    logic           RESETN                = 1'b0;
    logic           CFG_LOAD              = 1'b0;
    logic [15:0]    CFG_DATA              = 16'h0000;
    logic           RESET_POWERDOWN_PIN_N = 1'b1;
    logic           CLOCK_PIN;
    logic           LATCH_ENABLE_N;
    logic           CHIP_ENABLE_N;
    logic [AW-1:0]  ADDRESS;
    logic           ASYNC_READ;
    logic           STALL_INDICATOR;
    logic           DATA_VALID;
    logic [AW-1:0]  WORD_ADDRESS;
    power_mode_type POWER_MODE;
    logic           LATENCY_RESERVED;
    int             n_errors  = 0;
    int             compares  = 0;
    int             cycles    = 0;
    int             n_stall   = 0;
    int             lat_cnt   = 0;
    int             lat_seen  = -1;
    logic           latching  = 1'b0;
    logic           pin_prev  = 1'b0;
    logic           dv_prev   = 1'b0;
    logic           edge_rise = 1'b1;
    logic           dv_at_stall;
    logic [AW-1:0]  last_addr;
    logic [AW-1:0]  words[$];
    logic [31:0]    state     = 32'hEBCC;
    logic [31:0]    r;
    logic [AW-1:0]  corner[5] = '{22'h3C, 22'h3D, 22'h3E, 22'h3F, 22'h7D};

    burst_read_config #(.ADDR_WIDTH(AW)) i_burst_read_config (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .CFG_LOAD(CFG_LOAD), .CFG_DATA(CFG_DATA),
        .RESET_POWERDOWN_PIN_N(RESET_POWERDOWN_PIN_N), .CHIP_ENABLE_N(CHIP_ENABLE_N),
        .LATCH_ENABLE_N(LATCH_ENABLE_N), .CLOCK_PIN(CLOCK_PIN), .ADDRESS(ADDRESS),
        .ASYNC_READ(ASYNC_READ), .STALL_INDICATOR(STALL_INDICATOR), .DATA_VALID(DATA_VALID),
        .WORD_ADDRESS(WORD_ADDRESS), .POWER_MODE(POWER_MODE),
        .LATENCY_RESERVED(LATENCY_RESERVED));

    burst_host_model #(.ADDR_WIDTH(AW)) i_burst_host_model (
        .CORE_CLK(CORE_CLK), .CLOCK_PIN(CLOCK_PIN), .LATCH_ENABLE_N(LATCH_ENABLE_N),
        .CHIP_ENABLE_N(CHIP_ENABLE_N), .ADDRESS(ADDRESS));

    always #50 CORE_CLK = ~CORE_CLK;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [AW-1:0] exp_addr(input logic [AW-1:0] s, input int i,
                                               input int w, input logic inter, input logic lin);
        logic [AW-1:0] m;
        m = AW'(w - 1);
        if (lin)
            return s + AW'(i);
        if (inter)
            return s ^ AW'(i);
        return (s & ~m) | ((s + AW'(i)) & m);
    endfunction : exp_addr

    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK);
        #2;
    endtask : tick

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic load_cfg(input logic [15:0] value);
        CFG_LOAD = 1'b1;
        CFG_DATA = value;
        tick(1);
        CFG_LOAD = 1'b0;
        CFG_DATA = ~value;
        tick(1);
    endtask : load_cfg

    task automatic set_rp(input logic level);
        RESET_POWERDOWN_PIN_N = level;
        tick(3);
    endtask : set_rp

    task automatic run_burst(input logic rs, input logic [2:0] lat, input logic [2:0] len,
                             input logic inter, input logic nowrap, input logic edge_sel,
                             input logic wt, input logic [AW-1:0] start);
        int w;
        int half;
        int exp_st;
        w = (len == 3'h1) ? 4 : (len == 3'h2) ? 8 : 0;
        state = lfsr(state);
        half = 2 + int'(state[0]);
        // Spare bits carry random values and must change nothing
        load_cfg({rs, state[14], lat, 1'b0, state[9], wt, ~inter, edge_sel, state[5:4],
                  nowrap, len});
        edge_rise = edge_sel;
        latching = 1'b0;
        lat_seen = -1;
        n_stall = 0;
        words.delete();
        i_burst_host_model.half_cycles = half;
        i_burst_host_model.burst(start, int'(lat) + ((w == 0) ? 80 : w + 5));
        tick(4);
        chk("read mode", rs, ASYNC_READ);
        if (rs)
        begin
            chk("async words", 0, words.size());
            chk("async stall", 0, n_stall);
            return;
        end
        chk("latency", lat, lat_seen);
        if (w != 0)
            chk("words", w, words.size());
        else
            chk("long run", 1, words.size() > 60);
        foreach (words[i])
            chk("addr", exp_addr(start, i, w, inter, nowrap || w == 0), words[i]);
        exp_st = ((nowrap || w == 0) && int'(start[5:0]) + words.size() > 64) ? start[1:0] : 0;
        chk("stall", exp_st, (n_stall + half) / (2 * half));
        if (exp_st != 0)
            chk("stall lead", wt, dv_at_stall);
    endtask : run_burst

    always @(posedge CORE_CLK)
    begin
        cycles++;
        if (cycles == CEILING)
        begin
            n_errors++;
            stop_test();
        end
    end

    always @(posedge CORE_CLK)
    begin
        if (CLOCK_PIN !== pin_prev && CLOCK_PIN === edge_rise)
        begin
            if (!LATCH_ENABLE_N && !CHIP_ENABLE_N && !latching && lat_seen < 0)
            begin
                latching = 1'b1;
                lat_cnt = 0;
            end
            else if (latching)
                lat_cnt++;
        end
        if (DATA_VALID === 1'b1 && latching)
        begin
            latching = 1'b0;
            lat_seen = lat_cnt;
        end
        if (DATA_VALID === 1'b1 && (words.size() == 0 || WORD_ADDRESS !== words[$]))
            words.push_back(WORD_ADDRESS);
        if (STALL_INDICATOR === 1'b1)
        begin
            if (n_stall == 0)
                dv_at_stall = DATA_VALID;
            n_stall++;
        end
        pin_prev = CLOCK_PIN;
        dv_prev = DATA_VALID;
        last_addr = WORD_ADDRESS;
    end

    initial
    begin
        tick(10);
        RESETN = 1'b1;
        tick(1);
        chk("reset read mode", 1, ASYNC_READ);
        chk("reset power", MODE_ACTIVE, POWER_MODE);
        chk("reset valid", 0, DATA_VALID);
        load_cfg(16'hBDCF);
        set_rp(1'b0);
        chk("power down", MODE_POWERDOWN, POWER_MODE);
        set_rp(1'b1);
        set_rp(1'b0);
        chk("standby", MODE_STANDBY, POWER_MODE);
        set_rp(1'b1);
        load_cfg(16'hBDCF);
        RESETN = 1'b0;
        tick(2);
        RESETN = 1'b1;
        tick(1);
        set_rp(1'b0);
        chk("standby after reset", MODE_STANDBY, POWER_MODE);
        set_rp(1'b1);
        for (int c = 0; c < 8; c++)
        begin
            load_cfg({2'b10, 3'(c), 11'h1CF});
            chk("latency code", (c < 2 || c > 5), LATENCY_RESERVED);
        end
        run_burst(1'b1, 3'h3, 3'h7, 1'b0, 1'b0, 1'b1, 1'b1, 22'h3D);
        for (int k = 0; k < 5; k++)
            run_burst(1'b0, 3'(2 + k % 4), 3'h7, 1'b0, 1'b0, k[0], k[0], corner[k]);
        run_burst(1'b0, 3'h5, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 22'h7D);
        run_burst(1'b0, 3'h4, 3'h2, 1'b0, 1'b1, 1'b1, 1'b1, 22'h3E);
        run_burst(1'b0, 3'h2, 3'h1, 1'b0, 1'b0, 1'b1, 1'b1, 22'h3F);
        run_burst(1'b0, 3'h3, 3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 22'h07);
        for (int k = 0; k < 14; k++)
        begin
            state = lfsr(state);
            r = state;
            run_burst(1'b0, 3'h2 + {1'b0, r[7:6]}, r[3] ? 3'h7 : {1'b0, r[2], ~r[2]},
                      r[5] & ~r[4] & ~r[3], r[4], r[8], r[9], r[31:10]);
        end
        stop_test();
    end
endmodule : tb_burst_read_config
